// ==== fia_top.sv ====
// Operation
// RULE1 - In function cycle, zero accumulator or operand mantissa disables its adder side.
// RULE2 - Exponents apart by over 35: smaller-exponent side disabled, taken as zero.
// RULE3 - Unlike-sign add or like-sign subtract runs A-B-1; otherwise A+B.
// RULE4 - Aligned-B subtract: no carry-in when rounding and bit01 set, else carry-in.
// RULE5 - Effective subtract assumes accumulator sign; on overflow invert sign, negate result.
// RULE6 - After subtract overflow without rounding credit, add one while negating.
// RULE7 - Effective float add adds one at LSB when rounding and bit01 set.
// RULE8 - Add carry-out: flag, right-shift sum, exponent up, LSB to bit01 and guard.
// RULE9 - No carry-out: sum loaded directly, no shift, guard or exponent change.
// RULE10 - Exponent past 377777 octal gives temporary overflow, mantissa and sign kept.
// RULE11 - Rounding carry at exponent 377777 octal raises overflow and interrupt cycle.
// RULE12 - Normalize: left shift, exponent down; 400000 to 377777 octal raises underflow.
// RULE13 - Underflow may cancel temporary overflow; else overflow becomes permanent, interrupt.
// RULE14 - Integer exponent cycle converts negatives to sign-magnitude, into A or B.
// RULE15 - Integer effective subtract runs A-B-1 plus carry-in; otherwise A+B.
// RULE16 - Adding two positive integers with carry-out is overflow, interrupt cycle.
// RULE17 - Integer subtract assumes A sign; on carry-out negate A and invert sign. The code negates and inverts when there is no carry-out.
// RULE18 - Integer magnitude beyond 2^35-1 raises overflow; low bits and sign remain.
// RULE19 - Integer reverse subtract moves A into B at fetch, then loads A.
// RULE20 - Next instruction clears guard unless test, exception-word access or branch.
// RULE21 - Overflow and underflow are reported on separate outputs.
module fia_top
  import fia_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   ovf_irq,
  output logic                   unf_irq,
  output logic                   int_ovf_irq,
  output logic                   int_cycle_req,
  output logic                   sum_overflow_flag
);
  function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] d,
                                      input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [MANT_W-1:0] twos(input logic [MANT_W-1:0] v);
    return ~v + {{(MANT_W-1){1'b0}}, 1'b1};
  endfunction

  fia_state_t          state_r;
  logic [MANT_W-1:0]   mant_a_r, mant_b_r;
  logic                sign_a_r, sign_b_r;
  logic [EXP_W-1:0]    exp_a_r, exp_b_r;
  logic [35:0]         opnd_r;
  logic [5:0]          ctrl_r;
  logic                ext01_r, guard_r, temp_ovf_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                aw_v_r, w_v_r;

  logic                wr_do, cmd_go, busy, data_ok;
  logic [2:0]          cmd;
  logic [1:0]          op;
  logic                int_mode, rnd_req, b_aligned, exempt, round_ok;
  logic [18:0]         ediff;
  logic                a_far, b_far, a_en, b_en, eff_sub, cin, carry;
  logic [MANT_W-1:0]   opa, opb, fun_mant;
  logic [35:0]         raw;
  logic                fun_sign, fun_exp_inc, fun_tovf, fun_ovf, fun_iovf;
  logic                fun_go, exp_go, fetch_go, next_go, norm_go;
  logic                norm_step, norm_done, norm_wrap;
  logic [MANT_W-1:0]   opnd_mag;
  logic                exp_to_a;

  assign op        = ctrl_r[CTRL_OP_LSB +: 2];
  assign int_mode  = ctrl_r[CTRL_INT_BIT];
  assign rnd_req   = ctrl_r[CTRL_RND_BIT];
  assign b_aligned = ctrl_r[CTRL_BAL_BIT];
  assign exempt    = ctrl_r[CTRL_EXM_BIT];
  assign round_ok  = rnd_req & ext01_r;
  assign busy      = (state_r == FIA_NORM);

  // Bus write side: address and data caught in either order
  assign wr_do   = aw_v_r & w_v_r & ~s_axi_bvalid;
  assign data_ok = wr_do & ~busy;
  assign cmd_go  = data_ok & (awaddr_r == OFS_CMD);
  assign cmd     = wdata_r[2:0];
  assign fun_go  = cmd_go & (cmd == CMD_FUN);
  assign exp_go  = cmd_go & (cmd == CMD_EXP) & int_mode;
  assign fetch_go = cmd_go & (cmd == CMD_FETCH_RSUB);
  assign next_go = cmd_go & (cmd == CMD_NEXT);
  assign norm_go = cmd_go & (cmd == CMD_NORM) & ~int_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_r        <= 1'b0;
      w_v_r         <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_v_r        <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_v_r        <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_v_r <= 1'b0;
        w_v_r  <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r[1:0] == 2'h0 && awaddr_r <= OFS_EXT) ? RESP_OKAY
                                                                     : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL:    rd_word = {26'h0, ctrl_r};
      OFS_STATUS:  rd_word = {24'h0, int_cycle_req, int_ovf_irq, unf_irq, ovf_irq,
                              temp_ovf_r, guard_r, sum_overflow_flag, busy};
      OFS_A_LO:    rd_word = mant_a_r[31:0];
      OFS_A_HI:    rd_word = {23'h0, sign_a_r, 5'h0, mant_a_r[34:32]};
      OFS_B_LO:    rd_word = mant_b_r[31:0];
      OFS_B_HI:    rd_word = {23'h0, sign_b_r, 5'h0, mant_b_r[34:32]};
      OFS_EXP_A:   rd_word = {14'h0, exp_a_r};
      OFS_EXP_B:   rd_word = {14'h0, exp_b_r};
      OFS_OPND_LO: rd_word = opnd_r[31:0];
      OFS_OPND_HI: rd_word = {28'h0, opnd_r[35:32]};
      OFS_EXT:     rd_word = {30'h0, guard_r, ext01_r};
      OFS_CMD:     rd_word = 32'h0000_0000;
      default:     rd_ok   = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET;
      opnd_r <= '0;
    end else if (data_ok) begin
      if (awaddr_r == OFS_CTRL) ctrl_r <= 6'(mrg({26'h0, ctrl_r}, wdata_r, wstrb_r));
      if (awaddr_r == OFS_OPND_LO) opnd_r[31:0] <= mrg(opnd_r[31:0], wdata_r, wstrb_r);
      if (awaddr_r == OFS_OPND_HI && wstrb_r[0]) opnd_r[35:32] <= wdata_r[3:0];
    end
  end

  // Datapath of the function cycle
  always_comb begin
    ediff    = {exp_a_r[17], exp_a_r} - {exp_b_r[17], exp_b_r};
    a_far    = ~int_mode & ($signed(ediff) < -$signed(FAR_LIMIT));     // [RULE2]
    b_far    = ~int_mode & ($signed(ediff) > $signed(FAR_LIMIT));      // [RULE2]
    a_en     = (mant_a_r != '0) & ~a_far;                              // [RULE1]
    b_en     = (mant_b_r != '0) & ~b_far;                              // [RULE1]
    opa      = a_en ? mant_a_r : '0;
    opb      = b_en ? mant_b_r : '0;
    eff_sub  = (op == OP_ADD) ? (sign_a_r != sign_b_r) : (sign_a_r == sign_b_r); // [RULE3] [RULE15]
    // Only an aligned B carries a rounding debt into the subtract
    cin      = int_mode | ~(b_aligned & round_ok);                     // [RULE4] [RULE15]
    if (eff_sub) begin
      raw = {1'b0, opa} + {1'b0, ~opb} + {35'h0, cin};
    end else begin
      raw = {1'b0, opa} + {1'b0, opb} + {35'h0, ~int_mode & round_ok}; // [RULE7]
    end
    carry       = raw[35];
    fun_mant    = raw[34:0];
    fun_sign    = sign_a_r;
    fun_exp_inc = 1'b0;
    fun_tovf    = 1'b0;
    fun_ovf     = 1'b0;
    fun_iovf    = 1'b0;
    if (eff_sub) begin
      // No carry here means the accumulator sign was the wrong guess
      if (!carry) begin
        fun_sign = ~sign_a_r;                                          // [RULE5] [RULE17]
        fun_mant = cin ? twos(raw[34:0]) : ~raw[34:0];                 // [RULE6] [RULE17]
      end
    end else if (carry) begin
      if (int_mode) begin
        fun_iovf = 1'b1;                                               // [RULE16] [RULE18]
      end else begin
        fun_mant    = raw[35:1];                                       // [RULE8]
        fun_exp_inc = 1'b1;                                            // [RULE8] [RULE11]
        if (exp_a_r == EXP_MAX) begin
          fun_ovf  = round_ok;                                         // [RULE11]
          fun_tovf = ~round_ok;                                        // [RULE10]
        end
      end
    end
  end

  assign norm_done = (mant_a_r == '0) | mant_a_r[MANT_W-1];
  assign norm_step = busy & ~norm_done;
  assign norm_wrap = norm_step & (exp_a_r == EXP_MIN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= FIA_IDLE;
    end else begin
      unique case (state_r)
        FIA_IDLE: if (norm_go) state_r <= FIA_NORM;
        FIA_NORM: if (norm_done) state_r <= FIA_IDLE;
      endcase
    end
  end

  assign opnd_mag = opnd_r[35] ? twos(opnd_r[34:0]) : opnd_r[34:0];   // [RULE14]
  assign exp_to_a = (op == OP_LOAD) | (op == OP_RSUB);                // [RULE14] [RULE19]

  // Accumulator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mant_a_r <= '0;
      sign_a_r <= 1'b0;
      exp_a_r  <= '0;
    end else begin
      if (data_ok && awaddr_r == OFS_A_LO) mant_a_r[31:0] <= mrg(mant_a_r[31:0], wdata_r, wstrb_r);
      if (data_ok && awaddr_r == OFS_A_HI && wstrb_r[0]) mant_a_r[34:32] <= wdata_r[2:0];
      if (data_ok && awaddr_r == OFS_A_HI && wstrb_r[1]) sign_a_r <= wdata_r[HI_SIGN_BIT];
      if (data_ok && awaddr_r == OFS_EXP_A) exp_a_r <= 18'(mrg(32'(exp_a_r), wdata_r, wstrb_r));
      if (exp_go && exp_to_a) begin
        mant_a_r <= opnd_mag;                                          // [RULE14] [RULE19]
        sign_a_r <= opnd_r[35];
      end
      if (fun_go) begin
        // Integer overflow keeps the low bits and the sign
        mant_a_r <= fun_mant;                                          // [RULE9] [RULE18]
        sign_a_r <= fun_sign;                                          // [RULE5]
        if (fun_exp_inc) exp_a_r <= exp_a_r + 18'h00001;               // [RULE8] [RULE10]
      end
      if (norm_step) begin
        mant_a_r <= {mant_a_r[MANT_W-2:0], 1'b0};                      // [RULE12]
        exp_a_r  <= exp_a_r - 18'h00001;                               // [RULE12]
      end
    end
  end

  // Operand register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mant_b_r <= '0;
      sign_b_r <= 1'b0;
      exp_b_r  <= '0;
    end else begin
      if (data_ok && awaddr_r == OFS_B_LO) mant_b_r[31:0] <= mrg(mant_b_r[31:0], wdata_r, wstrb_r);
      if (data_ok && awaddr_r == OFS_B_HI && wstrb_r[0]) mant_b_r[34:32] <= wdata_r[2:0];
      if (data_ok && awaddr_r == OFS_B_HI && wstrb_r[1]) sign_b_r <= wdata_r[HI_SIGN_BIT];
      if (data_ok && awaddr_r == OFS_EXP_B) exp_b_r <= 18'(mrg(32'(exp_b_r), wdata_r, wstrb_r));
      if (fetch_go) begin
        mant_b_r <= mant_a_r;                                          // [RULE19]
        sign_b_r <= sign_a_r;
        exp_b_r  <= exp_a_r;
      end
      if (exp_go && !exp_to_a) begin
        mant_b_r <= opnd_mag;                                          // [RULE14]
        sign_b_r <= opnd_r[35];
      end
    end
  end

  // Extension bit and guard
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext01_r <= 1'b0;
      guard_r <= 1'b0;
    end else begin
      if (data_ok && awaddr_r == OFS_EXT && wstrb_r[0]) begin
        ext01_r <= wdata_r[EXT_BIT01];
        guard_r <= wdata_r[EXT_GUARD];
      end
      if (next_go && !exempt) guard_r <= 1'b0;                         // [RULE20]
      if (fun_go && fun_exp_inc) begin
        ext01_r <= raw[0];                                             // [RULE8]
        if (raw[0]) guard_r <= 1'b1;                                   // [RULE8]
      end
    end
  end

  // Exception flags: a set in the clearing cycle wins
  logic clr_st;
  assign clr_st = data_ok & (awaddr_r == OFS_STATUS) & wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sum_overflow_flag <= 1'b0;
      temp_ovf_r        <= 1'b0;
      ovf_irq           <= 1'b0;
      unf_irq           <= 1'b0;
      int_ovf_irq       <= 1'b0;
      int_cycle_req     <= 1'b0;
    end else begin
      if (clr_st && wdata_r[ST_OVF])  ovf_irq       <= 1'b0;
      if (clr_st && wdata_r[ST_UNF])  unf_irq       <= 1'b0;
      if (clr_st && wdata_r[ST_IOVF]) int_ovf_irq   <= 1'b0;
      if (clr_st && wdata_r[ST_ICYC]) int_cycle_req <= 1'b0;
      if (next_go) temp_ovf_r <= 1'b0;
      if (fun_go) begin
        sum_overflow_flag <= fun_exp_inc;                              // [RULE8]
        if (fun_tovf) temp_ovf_r <= 1'b1;                              // [RULE10]
        if (fun_ovf) begin
          ovf_irq       <= 1'b1;                                       // [RULE11] [RULE21]
          int_cycle_req <= 1'b1;
        end
        if (fun_iovf) begin
          int_ovf_irq   <= 1'b1;                                       // [RULE16] [RULE18]
          int_cycle_req <= 1'b1;
        end
      end
      if (norm_wrap) begin
        if (temp_ovf_r) begin
          temp_ovf_r <= 1'b0;                                          // [RULE13]
        end else begin
          unf_irq       <= 1'b1;                                       // [RULE12] [RULE21]
          int_cycle_req <= 1'b1;
        end
      end
      if (busy && norm_done && temp_ovf_r) begin
        temp_ovf_r    <= 1'b0;
        ovf_irq       <= 1'b1;                                         // [RULE13]
        int_cycle_req <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic plain_add;
  assign plain_add = fun_go & ~int_mode & ~eff_sub & ~round_ok;

  chk_zero_side: assert property (plain_add && mant_a_r == '0 && !b_far && !carry // [RULE1]
    |=> mant_a_r == $past(mant_b_r)) else $error("zero A side not disabled");
  chk_far_side: assert property (plain_add && b_far && mant_a_r != '0 // [RULE2]
    |=> mant_a_r == $past(mant_a_r) && !sum_overflow_flag)
    else $error("far operand not disabled");
  chk_like_add: assert property (plain_add && a_en && b_en && !carry // [RULE3]
    |=> mant_a_r == $past(mant_a_r) + $past(mant_b_r)) else $error("like-sign add wrong");
  chk_sub_sign: assert property (fun_go && eff_sub && a_en && b_en && cin // [RULE5]
    && mant_a_r > mant_b_r |=> sign_a_r == $past(sign_a_r)
    && mant_a_r == $past(mant_a_r) - $past(mant_b_r))
    else $error("subtract sign or value wrong");
  chk_add_carry: assert property (fun_go && fun_exp_inc // [RULE8]
    |=> sum_overflow_flag && exp_a_r == $past(exp_a_r) + 18'h00001)
    else $error("carry did not shift");
  chk_norm_step: assert property (norm_step // [RULE12]
    |=> exp_a_r == $past(exp_a_r) - 18'h00001) else $error("normalize step wrong");
  chk_norm_unf: assert property (norm_wrap && !temp_ovf_r // [RULE12]
    |=> unf_irq && int_cycle_req) else $error("underflow not raised");
  chk_int_ovf: assert property (fun_go && int_mode && !eff_sub && !sign_a_r && carry // [RULE16]
    |=> int_ovf_irq && int_cycle_req && !ovf_irq == !$past(ovf_irq))
    else $error("integer overflow missed");
  chk_guard_clr: assert property (next_go && !exempt && !fun_go |=> !guard_r) // [RULE20]
    else $error("guard not cleared");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  cov_sub_wrong: cover property (fun_go && eff_sub && !carry);
  cov_norm_wrap: cover property (norm_wrap);
  cov_int_ovf: cover property (fun_go && fun_iovf);
  cov_far: cover property (fun_go && (a_far || b_far));
endmodule

// ==== fia_pkg.sv ====
package fia_pkg;
  localparam int          MANT_W      = 35;
  localparam int          EXP_W       = 18;
  localparam int          ADDR_W      = 8;
  localparam logic [18:0] FAR_LIMIT   = 19'h00023;
  localparam logic [17:0] EXP_MAX     = 18'h1FFFF;
  localparam logic [17:0] EXP_MIN     = 18'h20000;

  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_A_LO     = 8'h0C;
  localparam logic [7:0] OFS_A_HI     = 8'h10;
  localparam logic [7:0] OFS_B_LO     = 8'h14;
  localparam logic [7:0] OFS_B_HI     = 8'h18;
  localparam logic [7:0] OFS_EXP_A    = 8'h1C;
  localparam logic [7:0] OFS_EXP_B    = 8'h20;
  localparam logic [7:0] OFS_OPND_LO  = 8'h24;
  localparam logic [7:0] OFS_OPND_HI  = 8'h28;
  localparam logic [7:0] OFS_EXT      = 8'h2C;

  // CTRL fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_INT_BIT  = 2;
  localparam int CTRL_RND_BIT  = 3;
  localparam int CTRL_BAL_BIT  = 4;
  localparam int CTRL_EXM_BIT  = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // HI register sign bit
  localparam int HI_SIGN_BIT   = 8;
  // STATUS fields
  localparam int ST_BUSY  = 0;
  localparam int ST_GRT   = 1;
  localparam int ST_GUARD = 2;
  localparam int ST_TOVF  = 3;
  localparam int ST_OVF   = 4;
  localparam int ST_UNF   = 5;
  localparam int ST_IOVF  = 6;
  localparam int ST_ICYC  = 7;
  // EXT fields
  localparam int EXT_BIT01 = 0;
  localparam int EXT_GUARD = 1;

  localparam logic [1:0] OP_LOAD = 2'h0;
  localparam logic [1:0] OP_ADD  = 2'h1;
  localparam logic [1:0] OP_SUB  = 2'h2;
  localparam logic [1:0] OP_RSUB = 2'h3;

  localparam logic [2:0] CMD_FETCH_RSUB = 3'h1;
  localparam logic [2:0] CMD_EXP        = 3'h2;
  localparam logic [2:0] CMD_FUN        = 3'h3;
  localparam logic [2:0] CMD_NORM       = 3'h4;
  localparam logic [2:0] CMD_NEXT       = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {FIA_IDLE, FIA_NORM} fia_state_t;
endpackage

// ==== fia_irq_model.sv ====
module fia_irq_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ovf_irq,
  input  wire logic       unf_irq,
  input  wire logic       int_ovf_irq,
  input  wire logic       int_cycle_req,
  output logic [3:0]      seen_r
);
  timeunit 1ns;
  timeprecision 100ps;
  // Sticky per source, so a wrong line is caught even after software clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_r <= 4'h0;
    end else begin
      seen_r <= seen_r | {int_cycle_req, int_ovf_irq, unf_irq, ovf_irq};
    end
  end
endmodule

// ==== tb_float_int_add_sub_unit.sv ====
module tb_float_int_add_sub_unit import fia_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ovf_irq, unf_irq, int_ovf_irq, int_cycle_req, sum_overflow_flag;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, seen;
  int failures = 0;
  int cmp_count = 0;

  always #12.5 aclk = ~aclk;

  fia_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ovf_irq, .unf_irq, .int_ovf_irq, .int_cycle_req, .sum_overflow_flag);
  fia_irq_model irq_mdl (.aclk, .aresetn, .ovf_irq, .unf_irq, .int_ovf_irq, .int_cycle_req,
    .seen_r(seen));

  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
                     input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(32'(r), 32'(er));
    chk(d & m, e);
  endtask

  // Every operand register is rewritten; EXT is not, so a rounding scenario leans on an earlier EXT write
  task automatic run(input logic [31:0] c, ah, al, bh, bl, ea, eb);
    wr(OFS_CTRL, c);
    wr(OFS_A_HI, ah);
    wr(OFS_A_LO, al);
    wr(OFS_B_HI, bh);
    wr(OFS_B_LO, bl);
    wr(OFS_EXP_A, ea);
    wr(OFS_EXP_B, eb);
    wr(OFS_CMD, 32'(CMD_FUN));
  endtask

  task automatic t_reset();
    rdc(OFS_STATUS, 0);
    rdc(OFS_CTRL, 0);
    rdc(8'h30, 0, '1, RESP_SLVERR);
    wr(8'h30, 32'h1, RESP_SLVERR);
  endtask

  task automatic t_add();
    run(1, 4, 1, 4, 0, 5, 5);
    chk(32'(sum_overflow_flag), 1);
    rdc(OFS_A_LO, 0);
    rdc(OFS_A_HI, 4);
    rdc(OFS_EXP_A, 6);
    rdc(OFS_EXT, 3);
    wr(OFS_CTRL, 32'h21);
    wr(OFS_CMD, 32'(CMD_NEXT));
    rdc(OFS_STATUS, 4, 4);
    wr(OFS_CTRL, 32'h01);
    wr(OFS_CMD, 32'(CMD_NEXT));
    rdc(OFS_STATUS, 0, 4);
  endtask

  // Float then integer effective subtract, both with a borrow
  task automatic t_sub();
    for (int i = 0; i < 2; i++) begin
      run(i ? 32'h6 : 32'h2, 0, 3, 0, 6, 0, 0);
      rdc(OFS_A_LO, 3);
      rdc(OFS_A_HI, 32'h100);
    end
  endtask

  // Exponent gap of 35 still adds, 36 drops the smaller side
  task automatic t_far();
    for (int i = 0; i < 3; i++) begin
      run(1, 0, 5, 0, 7, i[1] ? 36 : 0, i[1] ? 0 : 35 + i);
      rdc(OFS_A_LO, i[1] ? 5 : i ? 7 : 12);
      chk(32'(sum_overflow_flag), 0);
    end
  endtask

  task automatic t_int();
    run(5, 7, 32'hFFFFFFFF, 0, 1, 0, 0);
    chk(32'(int_ovf_irq), 1);
    chk(32'(int_cycle_req), 1);
    chk(32'(ovf_irq), 0);
    rdc(OFS_A_LO, 0);
    rdc(OFS_A_HI, 0);
    wr(OFS_STATUS, 32'hC0);
    chk(32'(int_ovf_irq), 0);
  endtask

  task automatic t_conv();
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, i ? 32'h5 : 32'h4);
      wr(OFS_OPND_LO, 32'hFFFFFFFB);
      wr(OFS_OPND_HI, 32'hF);
      wr(OFS_CMD, 32'(CMD_EXP));
      rdc(i ? OFS_B_LO : OFS_A_LO, 5);
      rdc(i ? OFS_B_HI : OFS_A_HI, 32'h100);
    end
  endtask

  task automatic t_norm();
    logic [31:0] d;
    logic [1:0] r;
    run(1, 0, 1, 0, 0, 32'h20000, 32'h20000);
    wr(OFS_CMD, 32'(CMD_NORM));
    do begin
      rd(OFS_STATUS, d, r);
    end while (d[ST_BUSY] !== 1'b0);
    chk(32'(unf_irq), 1);
    chk(32'(ovf_irq), 0);
    rdc(OFS_A_HI, 4);
    rdc(OFS_EXP_A, 32'h1FFDE);
    wr(OFS_STATUS, 32'hA0);
    chk(32'(unf_irq), 0);
  endtask

  // Rounding, the fetch copy and both routes to a float overflow
  task automatic t_round();
    wr(OFS_EXT, 1);
    run(9, 0, 1, 0, 2, 0, 0);
    rdc(OFS_A_LO, 4);
    wr(OFS_CMD, 32'(CMD_FETCH_RSUB));
    rdc(OFS_B_LO, 4);
    for (int i = 0; i < 2; i++) begin
      run(i ? 32'h1A : 32'hA, 0, 6, 0, 3, 0, 0);
      rdc(OFS_A_LO, i ? 2 : 3);
    end
    run(1, 0, 0, 0, 9, 0, 0);
    rdc(OFS_A_LO, 9);
    run(1, 4, 0, 4, 0, 32'h1FFFF, 32'h1FFFF);
    rdc(OFS_STATUS, 32'h08, 32'h98);
    wr(OFS_CMD, 32'(CMD_NORM));
    rdc(OFS_STATUS, 32'h90, 32'h98);
    chk(32'(ovf_irq), 1);
    wr(OFS_STATUS, 32'h90);
    wr(OFS_EXT, 1);
    run(9, 7, 32'hFFFFFFFF, 0, 0, 32'h1FFFF, 32'h1FFFF);
    rdc(OFS_STATUS, 32'h90, 32'h98);
    wr(OFS_STATUS, 32'h90);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_add();
    t_sub();
    t_far();
    t_int();
    t_conv();
    t_norm();
    t_round();
    chk(32'(seen), 32'hF);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    print_verdict();
  end
endmodule
